// file: cdsr_cfg.svh
`ifndef CDSR_CFG_SVH
`define CDSR_CFG_SVH
`define CDSR_OFF_OSC0 8'h07
`define CDSR_OFF_OSC1 8'h08
`define CDSR_OFF_OSC2 8'h09
`define CDSR_OFF_OSC3 8'h0A
`define CDSR_OFF_MEMSZ 8'h0C
`define CDSR_OFF_SSTAT 8'h10
`define CDSR_OFF_SVPC 8'h11
`define CDSR_OFF_SVSP 8'h12
`define CDSR_OFF_RDTHR 8'h13
`define CDSR_OFF_RDREG 8'h14
`define CDSR_OFF_CAUSE 8'h15
`define CDSR_OFF_INFO 8'h16
`define CDSR_OFF_STOP 8'h18
`define CDSR_OFF_SCR_LO 8'h20
`define CDSR_OFF_SCR_HI 8'h27
`define CDSR_OFF_BPA_LO 8'h30
`define CDSR_OFF_BPA_HI 8'h33
`define CDSR_OFF_BPC_LO 8'h40
`define CDSR_OFF_BPC_HI 8'h43
`define CDSR_SSTAT_MASK 32'h000007DF
`define CDSR_SSTAT_ISSUE_BIT 8
`define CDSR_BPC_MASK 32'h00FF0003
`define CDSR_BPC_EN_BIT 0
`define CDSR_BPC_COND_BIT 1
`define CDSR_BPC_THR_LSB 16
`define CDSR_CAUSE_BP_LSB 16
`define CDSR_CAUSE_THR_LSB 8
`define CDSR_MEMSZ_MASK 32'hFFFFFFFC
`define CDSR_OSC_W 16
`endif

// file: cdsr_pkg.sv
package cdsr_pkg;
  typedef enum logic [2:0] {
    CDSR_CAUSE_NONE = 3'h0,
    CDSR_CAUSE_HOST = 3'h1,
    CDSR_CAUSE_DBGCALL = 3'h2,
    CDSR_CAUSE_IBP = 3'h3,
    CDSR_CAUSE_DWP = 3'h4,
    CDSR_CAUSE_RWP = 3'h5
  } cdsr_cause_t;
endpackage

// file: cdsr_regs.sv
`timescale 1ns/100ps
`include "cdsr_cfg.svh"
module cdsr_regs
  import cdsr_pkg::*;
#(
  parameter int NTHR = 8,
  parameter logic [31:0] MEM_BYTES = 32'h00040000
)(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] osc_clk,
  input wire logic [3:0] osc_run,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [2:0] cfg_idx,
  input wire logic [31:0] cfg_wdata,
  input wire logic dbg_entry,
  input wire cdsr_pkg::cdsr_cause_t entry_cause,
  input wire logic [7:0] entry_thread,
  input wire logic [1:0] entry_wp_num,
  input wire logic [31:0] entry_info,
  input wire logic [31:0] entry_status,
  input wire logic [31:0] entry_pc,
  input wire logic [31:0] entry_sp,
  input wire logic pc_valid,
  input wire logic [7:0] pc_thread,
  input wire logic [31:0] pc_value,
  input wire logic in_debug,
  output logic [31:0] reg_rdata_ff,
  output logic [31:0] cfg_rdata_ff,
  output logic bp_hit_ff,
  output logic [1:0] bp_num_ff,
  output logic [7:0] bp_thread_ff,
  output logic [7:0] rd_thread_ff,
  output logic [4:0] rd_reg_ff,
  output logic [7:0] thread_hold_ff
);
  import cdsr_pkg::*;

  // ****************************************
  // Ring oscillator counters
  // ****************************************
  // Counters have no reset at all so a system reset keeps them; they start at zero
  // from power-up initialisation only. Reads are meaningful once the oscillator
  // has been stopped long enough for the synchronised copy to settle.
  logic [`CDSR_OSC_W-1:0] osc_cnt [4];
  logic [`CDSR_OSC_W-1:0] osc_s1_ff [4];
  logic [`CDSR_OSC_W-1:0] osc_s2_ff [4];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_osc
      logic [`CDSR_OSC_W-1:0] cnt_ff = '0;
      always_ff @(posedge osc_clk[gi])
      begin
        if (osc_run[gi])
          cnt_ff <= cnt_ff + 16'h0001;
      end
      assign osc_cnt[gi] = cnt_ff;
      always_ff @(posedge sys_clk)
      begin
        if (clk_en)
        begin
          osc_s1_ff[gi] <= osc_cnt[gi];
          osc_s2_ff[gi] <= osc_s1_ff[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Debug state registers
  // ****************************************
  logic [31:0] sstat_ff, svpc_ff, svsp_ff, info_ff;
  logic [7:0] rdthr_ff, stop_ff;
  logic [4:0] rdreg_ff;
  logic [2:0] cause_ff;
  logic [1:0] cbp_ff;
  logic [7:0] cthr_ff;
  logic [31:0] scr_ff [8];
  logic [31:0] bpa_ff [4];
  logic [31:0] bpc_ff [4];
  logic [31:0] rd_mux;
  logic [31:0] cfg_mux;
  logic wr_scr, wr_bpa, wr_bpc;
  logic [2:0] scr_i;
  logic [1:0] bp_i;

  assign scr_i = reg_addr[2:0];
  assign bp_i = reg_addr[1:0];
  assign wr_scr = reg_wr && reg_addr >= `CDSR_OFF_SCR_LO && reg_addr <= `CDSR_OFF_SCR_HI;
  assign wr_bpa = reg_wr && reg_addr >= `CDSR_OFF_BPA_LO && reg_addr <= `CDSR_OFF_BPA_HI;
  assign wr_bpc = reg_wr && reg_addr >= `CDSR_OFF_BPC_LO && reg_addr <= `CDSR_OFF_BPC_HI;

  // Entry capture wins over a software write in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sstat_ff <= 32'h00000000;
      svpc_ff <= 32'h00000000;
      svsp_ff <= 32'h00000000;
    end
    else if (clk_en)
    begin
      if (dbg_entry)
      begin
        sstat_ff <= entry_status & `CDSR_SSTAT_MASK;
        svpc_ff <= entry_pc;
        svsp_ff <= entry_sp;
      end
      else if (reg_wr)
      begin
        if (reg_addr == `CDSR_OFF_SSTAT)
          sstat_ff <= ((reg_wdata & `CDSR_SSTAT_MASK) & ~(32'h1 << `CDSR_SSTAT_ISSUE_BIT))
                      | (sstat_ff & (32'h1 << `CDSR_SSTAT_ISSUE_BIT));
        if (reg_addr == `CDSR_OFF_SVPC)
          svpc_ff <= reg_wdata;
        if (reg_addr == `CDSR_OFF_SVSP)
          svsp_ff <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cause_ff <= 3'h0;
      cbp_ff <= 2'h0;
      cthr_ff <= 8'h00;
      info_ff <= 32'h00000000;
    end
    else if (clk_en)
    begin
      if (dbg_entry)
      begin
        cause_ff <= entry_cause;
        cbp_ff <= (entry_cause == CDSR_CAUSE_HOST || entry_cause == CDSR_CAUSE_DBGCALL) ?
                  2'h0 : (entry_cause == CDSR_CAUSE_IBP ? bp_num_ff : entry_wp_num);
        cthr_ff <= (entry_cause == CDSR_CAUSE_HOST) ? 8'h00 : entry_thread;
        if (entry_cause == CDSR_CAUSE_DWP || entry_cause == CDSR_CAUSE_RWP)
          info_ff <= entry_info;
      end
      else if (reg_wr)
      begin
        if (reg_addr == `CDSR_OFF_CAUSE)
        begin
          cause_ff <= reg_wdata[2:0];
          cthr_ff <= reg_wdata[`CDSR_CAUSE_THR_LSB+:8];
          cbp_ff <= reg_wdata[`CDSR_CAUSE_BP_LSB+:2];
        end
        if (reg_addr == `CDSR_OFF_INFO)
          info_ff <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rdthr_ff <= 8'h00;
      rdreg_ff <= 5'h00;
      stop_ff <= 8'h00;
    end
    else if (clk_en && reg_wr)
    begin
      if (reg_addr == `CDSR_OFF_RDTHR)
        rdthr_ff <= reg_wdata[7:0];
      if (reg_addr == `CDSR_OFF_RDREG)
        rdreg_ff <= reg_wdata[4:0];
      if (reg_addr == `CDSR_OFF_STOP)
        stop_ff <= reg_wdata[7:0];
    end
  end

  // Register-port write (wr_scr) wins when both ports hit the same scratch word
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 8; i++)
        scr_ff[i] <= 32'h00000000;
    end
    else if (clk_en)
    begin
      if (cfg_wr)
        scr_ff[cfg_idx] <= cfg_wdata;
      if (wr_scr)
        scr_ff[scr_i] <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        bpa_ff[i] <= 32'h00000000;
        bpc_ff[i] <= 32'h00000000;
      end
    end
    else if (clk_en)
    begin
      if (wr_bpa)
        bpa_ff[bp_i] <= reg_wdata;
      if (wr_bpc)
        bpc_ff[bp_i] <= reg_wdata & `CDSR_BPC_MASK;
    end
  end

  // ****************************************
  // Breakpoint match
  // ****************************************
  logic [3:0] bp_match;
  logic [1:0] bp_low;
  always_comb
  begin
    bp_low = 2'h0;
    for (int i = 0; i < 4; i++)
      bp_match[i] = pc_valid && bpc_ff[i][`CDSR_BPC_EN_BIT]
                    && pc_thread < 8'(NTHR)
                    && bpc_ff[i][`CDSR_BPC_THR_LSB + pc_thread[2:0]]
                    && ((pc_value == bpa_ff[i]) ^ bpc_ff[i][`CDSR_BPC_COND_BIT]);
    for (int i = 3; i >= 0; i--)
      if (bp_match[i])
        bp_low = 2'(i);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      bp_hit_ff <= 1'b0;
      bp_num_ff <= 2'h0;
      bp_thread_ff <= 8'h00;
    end
    else if (clk_en)
    begin
      bp_hit_ff <= |bp_match;
      // Number and thread hold the last hit so a later entry can still record it
      if (|bp_match)
      begin
        bp_num_ff <= bp_low;
        bp_thread_ff <= pc_thread;
      end
    end
  end

  // ****************************************
  // Outputs and read mux
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rd_thread_ff <= 8'h00;
      rd_reg_ff <= 5'h00;
      thread_hold_ff <= 8'h00;
    end
    else if (clk_en)
    begin
      rd_thread_ff <= rdthr_ff;
      rd_reg_ff <= rdreg_ff;
      thread_hold_ff <= in_debug ? 8'h00 : stop_ff;
    end
  end

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (reg_addr)
      `CDSR_OFF_OSC0: rd_mux = {16'h0000, osc_s2_ff[0]};
      `CDSR_OFF_OSC1: rd_mux = {16'h0000, osc_s2_ff[1]};
      `CDSR_OFF_OSC2: rd_mux = {16'h0000, osc_s2_ff[2]};
      `CDSR_OFF_OSC3: rd_mux = {16'h0000, osc_s2_ff[3]};
      `CDSR_OFF_MEMSZ: rd_mux = MEM_BYTES & `CDSR_MEMSZ_MASK;
      `CDSR_OFF_SSTAT: rd_mux = sstat_ff;
      `CDSR_OFF_SVPC: rd_mux = svpc_ff;
      `CDSR_OFF_SVSP: rd_mux = svsp_ff;
      `CDSR_OFF_RDTHR: rd_mux = {24'h000000, rdthr_ff};
      `CDSR_OFF_RDREG: rd_mux = {27'h0000000, rdreg_ff};
      `CDSR_OFF_CAUSE: rd_mux = {14'h0000, cbp_ff, cthr_ff, 5'h00, cause_ff};
      `CDSR_OFF_INFO: rd_mux = info_ff;
      `CDSR_OFF_STOP: rd_mux = {24'h000000, stop_ff};
      default:
      begin
        if (reg_addr >= `CDSR_OFF_SCR_LO && reg_addr <= `CDSR_OFF_SCR_HI)
          rd_mux = scr_ff[scr_i];
        else if (reg_addr >= `CDSR_OFF_BPA_LO && reg_addr <= `CDSR_OFF_BPA_HI)
          rd_mux = bpa_ff[bp_i];
        else if (reg_addr >= `CDSR_OFF_BPC_LO && reg_addr <= `CDSR_OFF_BPC_HI)
          rd_mux = bpc_ff[bp_i];
      end
    endcase
    cfg_mux = scr_ff[cfg_idx];
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata_ff <= 32'h00000000;
      cfg_rdata_ff <= 32'h00000000;
    end
    else if (clk_en)
    begin
      if (reg_rd)
        reg_rdata_ff <= rd_mux;
      if (cfg_rd)
        cfg_rdata_ff <= cfg_mux;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_cause_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && dbg_entry |=> cause_ff == $past(entry_cause))
    else $error("cause not captured");
  a_host_thread_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && dbg_entry && entry_cause == CDSR_CAUSE_HOST |=> cthr_ff == 8'h00 && cbp_ff == 2'h0)
    else $error("host entry thread not zero");
  a_pc_sp_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && dbg_entry |=> svpc_ff == $past(entry_pc) && svsp_ff == $past(entry_sp))
    else $error("pc or sp not captured");
  a_status_reserved: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sstat_ff & ~`CDSR_SSTAT_MASK) == 32'h0)
    else $error("status reserved bits set");
  a_osc_upper_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && reg_rd && reg_addr == `CDSR_OFF_OSC0 |=> reg_rdata_ff[31:16] == 16'h0000)
    else $error("osc upper half not zero");
  a_memsz_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && reg_rd && reg_addr == `CDSR_OFF_MEMSZ |=> reg_rdata_ff[1:0] == 2'h0)
    else $error("memory size low bits set");
  a_hold_debug: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && in_debug |=> thread_hold_ff == 8'h00)
    else $error("threads held in debug");
  a_bp_disabled: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && bpc_ff[0][`CDSR_BPC_EN_BIT] == 1'b0 && bpc_ff[1][`CDSR_BPC_EN_BIT] == 1'b0
    && bpc_ff[2][`CDSR_BPC_EN_BIT] == 1'b0 && bpc_ff[3][`CDSR_BPC_EN_BIT] == 1'b0
    |=> !bp_hit_ff)
    else $error("disabled breakpoint fired");
  a_bp_lowest: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && bp_match[0] |=> bp_hit_ff && bp_num_ff == 2'h0)
    else $error("lowest breakpoint not taken");
  a_scratch_share: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && cfg_wr && !wr_scr ##1 clk_en && cfg_rd && cfg_idx == $past(cfg_idx)
    |=> cfg_rdata_ff == $past(cfg_wdata, 2))
    else $error("scratch write lost");

  c_entry: cover property (@(posedge sys_clk) clk_en && dbg_entry);
  c_bp_hit: cover property (@(posedge sys_clk) bp_hit_ff);
  c_bp_differ: cover property (@(posedge sys_clk)
    bp_hit_ff && bpc_ff[bp_num_ff][`CDSR_BPC_COND_BIT]);
  c_hold: cover property (@(posedge sys_clk) thread_hold_ff != 8'h00);
endmodule

// file: cdsr_osc_model.sv
`timescale 1ns/100ps
// ****************************************
// Ring oscillators seen from the core
// ****************************************
module cdsr_osc_model (
  input wire logic [3:0] run_req,
  output logic [3:0] osc_clk,
  output logic [3:0] osc_run,
  output logic [15:0] cnt [4]
);
  for (genvar k = 0; k < 4; k++)
  begin : g_osc
    // Periods unrelated to the core clock so sampling phase keeps drifting
    initial
    begin
      osc_clk[k] = 1'b0;
      osc_run[k] = 1'b0;
      cnt[k] = 16'h0000;
      forever #(7 + 4 * k) osc_clk[k] = ~osc_clk[k];
    end
    // Enable is retimed to the oscillator so no count edge is split
    always @(negedge osc_clk[k])
      osc_run[k] <= run_req[k];
    always @(posedge osc_clk[k])
      if (osc_run[k])
        cnt[k] <= cnt[k] + 16'h0001;
  end
endmodule

// file: core_debug_status_regs_tb_top.sv
`timescale 1ns/100ps
module core_debug_status_regs_tb_top;
  import cdsr_pkg::*;
  localparam logic [31:0] MEMB = 32'h00012347;
  logic sys_clk, sys_rst, clk_en, reg_wr, reg_rd, cfg_wr, cfg_rd, dbg_entry, pc_valid, in_debug;
  logic [3:0] osc_clk, osc_run, run_req;
  logic [7:0] reg_addr, entry_thread, pc_thread, bp_thread_ff, rd_thread_ff, thread_hold_ff;
  logic [2:0] cfg_idx;
  logic [1:0] entry_wp_num, bp_num_ff, bpn;
  logic [4:0] rd_reg_ff;
  cdsr_cause_t entry_cause;
  logic [31:0] reg_wdata, cfg_wdata, entry_info, entry_status, entry_pc, entry_sp, pc_value;
  logic [31:0] reg_rdata_ff, cfg_rdata_ff, r;
  logic bp_hit_ff;
  logic [15:0] osc_cnt [4];
  logic [31:0] mdl [0:255];
  int n_fail, checks, seed;

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  cdsr_osc_model i_cdsr_osc_model (.run_req, .osc_clk, .osc_run, .cnt(osc_cnt));
  cdsr_regs #(.MEM_BYTES(MEMB)) i_cdsr_regs (.sys_clk, .sys_rst, .clk_en, .osc_clk, .osc_run,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .cfg_wr, .cfg_rd, .cfg_idx, .cfg_wdata,
    .dbg_entry, .entry_cause, .entry_thread, .entry_wp_num, .entry_info, .entry_status,
    .entry_pc, .entry_sp, .pc_valid, .pc_thread, .pc_value, .in_debug, .reg_rdata_ff,
    .cfg_rdata_ff, .bp_hit_ff, .bp_num_ff, .bp_thread_ff, .rd_thread_ff, .rd_reg_ff,
    .thread_hold_ff);

  // ****************************************
  // Reference model and bus tasks
  // ****************************************
  function automatic logic [31:0] wmask(input logic [7:0] ad);
    if (ad inside {[8'h11:8'h12], 8'h16, [8'h20:8'h27], [8'h30:8'h33]})
      return 32'hFFFFFFFF;
    case (ad)
      8'h10: return 32'h000006DF;
      8'h13, 8'h18: return 32'h000000FF;
      8'h14: return 32'h0000001F;
      8'h15: return 32'h0003FF07;
      8'h40, 8'h41, 8'h42, 8'h43: return 32'h00FF0003;
      default: return 32'h00000000;
    endcase
  endfunction

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wr(input logic [7:0] ad, input logic [31:0] d);
    reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    mdl[ad] = (mdl[ad] & ~wmask(ad)) | (d & wmask(ad));
    @(negedge sys_clk);
  endtask

  task rd(input logic [7:0] ad);
    reg_addr = ad;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk($sformatf("reg %h", ad), mdl[ad], reg_rdata_ff);
    @(negedge sys_clk);
  endtask

  task cfgx(input logic [2:0] ix, input logic [31:0] d);
    cfg_idx = ix;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
    mdl[8'h20 + ix] = d;
    cfg_rd = 1'b1;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    chk("cfg scratch", d, cfg_rdata_ff);
    @(negedge sys_clk);
  endtask

  task sweep;
    for (int k = 0; k < 4; k++)
      mdl[7 + k] = {16'h0000, osc_cnt[k]};
    for (int a = 0; a < 72; a++)
      rd(a[7:0]);
  endtask

  task rst;
    sys_rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int k = 0; k < 256; k++)
      mdl[k] = 32'h00000000;
    mdl[8'h0C] = MEMB & 32'hFFFFFFFC;
  endtask

  task bp(input logic [2:0] t, input logic [31:0] pc);
    logic h;
    logic [1:0] n;
    logic [31:0] c;
    h = 1'b0;
    n = 2'h0;
    // Walk downwards so the lowest firing number wins
    for (int k = 3; k >= 0; k--)
    begin
      c = mdl[8'h40 + k];
      if (c[0] && c[16 + t] && ((pc != mdl[8'h30 + k]) == c[1]))
      begin
        h = 1'b1;
        n = k[1:0];
      end
    end
    pc_valid = 1'b1;
    pc_thread = {5'h00, t};
    pc_value = pc;
    @(negedge sys_clk);
    pc_valid = 1'b0;
    chk("bp hit", {31'h0, h}, {31'h0, bp_hit_ff});
    if (h)
    begin
      chk("bp number", {30'h0, n}, {30'h0, bp_num_ff});
      chk("bp thread", {29'h0, t}, {24'h0, bp_thread_ff});
      bpn = n;
    end
    @(negedge sys_clk);
  endtask

  task ent(input int c);
    logic [31:0] w;
    r = $random(seed);
    entry_cause = cdsr_cause_t'(c);
    entry_thread = r[7:0];
    entry_wp_num = r[9:8];
    entry_info = $random(seed);
    entry_status = $random(seed);
    entry_pc = $random(seed);
    entry_sp = $random(seed);
    dbg_entry = 1'b1;
    @(negedge sys_clk);
    dbg_entry = 1'b0;
    w = {29'h0, c[2:0]};
    if (c != 1)
      w[15:8] = r[7:0];
    if (c >= 4)
      w[17:16] = r[9:8];
    if (c == 3)
      w[17:16] = bpn;
    mdl[8'h15] = w;
    if (c >= 4)
      mdl[8'h16] = entry_info;
    mdl[8'h10] = entry_status & 32'h000007DF;
    mdl[8'h11] = entry_pc;
    mdl[8'h12] = entry_sp;
    for (int a = 8'h10; a < 8'h17; a++)
      rd(a[7:0]);
  endtask

  task done(input string s);
    $display("test %s done", s);
  endtask

  task close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    {sys_rst, reg_wr, reg_rd, cfg_wr, cfg_rd, dbg_entry, pc_valid, in_debug} = 8'h00;
    {reg_addr, cfg_idx, entry_thread, entry_wp_num, pc_thread, run_req} = 33'h0;
    {reg_wdata, cfg_wdata, entry_info, entry_status, entry_pc, entry_sp, pc_value} = 224'h0;
    entry_cause = CDSR_CAUSE_NONE;
    clk_en = 1'b1;
    seed = 66;
    n_fail = 0;
    checks = 0;
    bpn = 2'h0;
    @(negedge sys_clk);
    rst;
    sweep;
    done("reset values");
    for (int a = 0; a < 72; a++)
      wr(a[7:0], $random(seed));
    sweep;
    @(negedge sys_clk);
    chk("read thread", mdl[8'h13], {24'h0, rd_thread_ff});
    chk("read reg", mdl[8'h14], {27'h0, rd_reg_ff});
    chk("hold", mdl[8'h18], {24'h0, thread_hold_ff});
    in_debug = 1'b1;
    @(negedge sys_clk);
    chk("hold in debug", 32'h0, {24'h0, thread_hold_ff});
    in_debug = 1'b0;
    done("write sweep");
    for (int k = 0; k < 8; k++)
    begin
      cfgx(k[2:0], $random(seed));
      rd(8'h20 + k[7:0]);
    end
    // A write while the clock enable is low must leave the word unchanged
    clk_en = 1'b0;
    reg_addr = 8'h20;
    reg_wdata = ~mdl[8'h20];
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    clk_en = 1'b1;
    @(negedge sys_clk);
    rd(8'h20);
    done("scratch");
    for (int n = 0; n < 3; n++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        wr(8'h30 + k[7:0], $random(seed));
        wr(8'h40 + k[7:0], (n == 0) ? 32'h00FF0001 : $random(seed));
      end
      wr(8'h32, mdl[8'h31]);
      bp(3'h4, mdl[8'h31]);
      for (int p = 0; p < 8; p++)
      begin
        r = $random(seed);
        bp(r[2:0], r[3] ? mdl[8'h30 + r[5:4]] : $random(seed));
      end
    end
    for (int k = 0; k < 4; k++)
      wr(8'h40 + k[7:0], (k == 2) ? 32'h00FF0003 : 32'h0);
    bp(3'h6, mdl[8'h32] ^ 32'h00000010);
    done("breakpoints");
    for (int c = 1; c < 6; c++)
      ent(c);
    done("debug entry");
    run_req = 4'hF;
    repeat (40) @(negedge sys_clk);
    run_req = 4'h0;
    repeat (12) @(negedge sys_clk);
    sweep;
    rst;
    sweep;
    done("oscillators");
    close_out;
  end

  initial
  begin
    #(50 * 20000);
    n_fail++;
    close_out;
  end
endmodule
